// ### verilog/evs_sequencer.sv
// Purpose: exception recognition, ordering and vectoring of the core
// Assumes: completion logic presents one next-completing instruction
// Notes: one exception taken per take cycle, redirect is a pulse unless a held hard reset pin or check source is retaken each cycle
`timescale 1ns/1ps
module evs_sequencer (
	// clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   reset,
	// external pins, asynchronous
	input  wire logic                   hard_reset_pin,
	input  wire logic                   soft_reset_pin,
	input  wire logic                   check_request_pin,
	input  wire logic                   transfer_error_ack,
	input  wire logic                   ext_irq_pin,
	input  wire logic                   sys_mgmt_irq_pin,
	// on-chip event sources
	input  wire logic [2:0]             double_bit_err,
	input  wire logic                   down_counter_msb,
	input  wire logic                   perf_limit_hit,
	input  wire logic                   perf_irq_enable,
	input  wire logic                   thermal_enable,
	input  wire logic [1:0]             thermal_over,
	// completion side
	input  wire evs_pkg::evs_cmpl_t     cmpl,
	input  wire logic                   cq_empty,
	input  wire logic [31:0]            restart_addr,
	output logic                        cmpl_hold,
	output logic                        dispatch_hold,
	// breakpoint setup
	input  wire logic [31:0]            instr_breakpoint_reg,
	input  wire logic                   breakpoint_translate_bit,
	input  wire logic                   breakpoint_enable_bit,
	// software access to machine state
	input  wire logic                   msr_wr,
	input  wire logic [31:0]            msr_wdata,
	input  wire logic                   handler_return,
	// state and fetch outputs
	output evs_pkg::evs_redirect_t      redirect_reg,
	output evs_pkg::evs_exc_t           active_exc_reg,
	output logic [31:0]                 save_restore_addr_reg,
	output logic [31:0]                 save_restore_state_reg,
	output logic [31:0]                 machine_state_reg,
	output logic                        check_stop_reg
);
	import evs_pkg::*;

	logic [5:0]  pin_s;          // synchronised pins
	evs_state_t  state_reg;      // run or check stop
	evs_state_t  state_next;     // next state
	logic        srst_d_reg;     // soft reset pin delayed
	logic        srst_pend_reg;  // soft reset edge seen
	logic        mck_pend_reg;   // machine check seen
	logic        dec_d_reg;      // decrementer msb delayed
	logic        dec_pend_reg;   // decrementer edge seen
	logic        perf_pend_reg;  // monitor limit seen
	logic        trace_pend_reg; // trace owed after completion
	logic [31:0] trace_addr_reg; // address after traced instruction

	// pins pass two flops before use
	evs_sync #(.WIDTH(6)) u_pin_sync (
		.sys_clk (sys_clk),
		.reset   (reset),
		.din     ({hard_reset_pin, soft_reset_pin, check_request_pin,
		           transfer_error_ack, ext_irq_pin, sys_mgmt_irq_pin}),
		.dout    (pin_s)
	);

	wire hard_s = pin_s[5];
	wire srst_s = pin_s[4];
	wire mcp_s  = pin_s[3];
	wire tea_s  = pin_s[2];
	wire ext_s  = pin_s[1];
	wire smi_s  = pin_s[0];

	// machine state bits
	wire ee = machine_state_reg[EVS_EXT_IRQ_ENABLE_BIT];
	wire me = machine_state_reg[EVS_CHECK_ENABLE_BIT];
	wire se = machine_state_reg[EVS_SINGLE_STEP_ENABLE];
	wire be = machine_state_reg[EVS_BRANCH_TRACE_ENABLE];
	wire ir = machine_state_reg[EVS_INSTR_TRANSLATE_ENABLE];

	// nonmaskable requests
	wire sysrst_req = hard_s | srst_pend_reg;
	wire mck_src    = mcp_s | tea_s | (|double_bit_err);
	wire mck_req    = mck_pend_reg & me;
	wire nmi_req    = sysrst_req | mck_req;
	wire run        = (state_reg == EVS_ST_RUN);
	wire gap        = redirect_reg.valid;

	// breakpoint compare on upper 30 address bits
	wire bp_hit = breakpoint_enable_bit & (breakpoint_translate_bit == ir)
		& (instr_breakpoint_reg[31:2] == cmpl.addr[31:2]);

	// instruction-caused causes, floating faults arrive precise
	wire sync_any = cmpl.valid & (cmpl.instr_storage_fault | cmpl.program_fault
		| cmpl.fpu_unavail | cmpl.system_call_op | cmpl.align_fault
		| cmpl.data_fault | bp_hit);

	// highest priority cause of one instruction
	wire evs_exc_t sync_sel =
		cmpl.instr_storage_fault ? EVS_X_ISI :
		cmpl.program_fault       ? EVS_X_PROGRAM :
		cmpl.fpu_unavail         ? EVS_X_FPU :
		cmpl.system_call_op      ? EVS_X_SYSCALL :
		cmpl.align_fault         ? EVS_X_ALIGN :
		cmpl.data_fault          ? EVS_X_DSI :
		                           EVS_X_INSTR_BREAKPOINT_REG;

	// maskable asynchronous sources
	wire therm_req = thermal_enable & (|thermal_over);
	wire async_src = smi_s | ext_s | perf_pend_reg | dec_pend_reg | therm_req;
	wire async_want = ee & async_src;
	// queue empty and nothing completing: restart address is known
	wire async_ok  = async_want & cq_empty & ~cmpl.valid;

	wire evs_exc_t async_sel =
		smi_s         ? EVS_X_SMI :
		ext_s         ? EVS_X_EXT :
		perf_pend_reg ? EVS_X_PERF :
		dec_pend_reg  ? EVS_X_DEC :
		                EVS_X_THERM;

	// overall selection, nonmaskable ones preempt
	wire evs_exc_t exc_sel =
		sysrst_req              ? EVS_X_RESET :
		mck_req                 ? EVS_X_MCHECK :
		(!run || gap)           ? EVS_X_NONE :
		trace_pend_reg          ? EVS_X_TRACE :
		sync_any                ? sync_sel :
		async_ok                ? async_sel :
		                          EVS_X_NONE;
	wire take = (exc_sel != EVS_X_NONE);

	// resume address saved for the handler
	wire [31:0] save_addr =
		(exc_sel == EVS_X_SYSCALL) ? cmpl.addr + EVS_INSTR_BYTES :
		(exc_sel == EVS_X_TRACE)   ? trace_addr_reg :
		(sync_any && exc_sel == sync_sel) ? cmpl.addr :
		                             restart_addr;

	// entry state: supervisor, interrupts and trace off, not recoverable
	wire [31:0] msr_take = machine_state_reg & ~EVS_MSR_TAKE_CLR;

	// instruction held while an exception is pending or its redirect is in flight
	assign cmpl_hold     = cmpl.valid & (take | gap | trace_pend_reg | !run);
	// stop dispatch so the queue can drain
	assign dispatch_hold = run & (async_want | trace_pend_reg);

	// completing instruction leaves trace debt
	wire retire    = cmpl.valid & ~cmpl_hold;
	wire trace_set = retire & ((se & ~cmpl.is_isync)
		| (be & cmpl.is_branch & ~cmpl.is_isync));

	// set wins over clear on every pending flag
	wire srst_next  = (srst_s & ~srst_d_reg)
		| (srst_pend_reg & ~(exc_sel == EVS_X_RESET));
	wire mck_next   = mck_src | (mck_pend_reg & ~(exc_sel == EVS_X_MCHECK || exc_sel == EVS_X_RESET));
	wire dec_next   = (down_counter_msb & ~dec_d_reg)
		| (dec_pend_reg & ~(exc_sel == EVS_X_DEC));
	wire perf_next  = (perf_limit_hit & perf_irq_enable)
		| (perf_pend_reg & ~(exc_sel == EVS_X_PERF));
	wire trace_next = trace_set | (trace_pend_reg & ~(exc_sel == EVS_X_TRACE));

	// check stop when a check arrives with checks disabled
	assign state_next = (exc_sel == EVS_X_RESET) ? EVS_ST_RUN :
		(mck_pend_reg && !me) ? EVS_ST_STOP : state_reg;

	// pending event flags
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			srst_d_reg     <= 1'b0;
			srst_pend_reg  <= 1'b0;
			mck_pend_reg   <= 1'b0;
			dec_d_reg      <= 1'b0;
			dec_pend_reg   <= 1'b0;
			perf_pend_reg  <= 1'b0;
			trace_pend_reg <= 1'b0;
		end
		else
		begin
			srst_d_reg     <= srst_s;
			srst_pend_reg  <= srst_next;
			mck_pend_reg   <= mck_next;
			dec_d_reg      <= down_counter_msb;
			dec_pend_reg   <= dec_next;
			perf_pend_reg  <= perf_next;
			trace_pend_reg <= trace_next;
		end
	end

	// address after the traced instruction
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			trace_addr_reg <= 32'h0000_0000;
		else if (trace_set)
			trace_addr_reg <= cmpl.next_addr;
	end

	// state machine and check stop flag
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			state_reg      <= EVS_ST_RUN;
			check_stop_reg <= 1'b0;
		end
		else
		begin
			state_reg      <= state_next;
			check_stop_reg <= (state_next == EVS_ST_STOP);
		end
	end

	// save registers, machine state, redirect
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			save_restore_addr_reg  <= 32'h0000_0000;
			save_restore_state_reg <= 32'h0000_0000;
			machine_state_reg      <= EVS_MSR_RST;
			redirect_reg           <= '0;
			active_exc_reg         <= EVS_X_NONE;
		end
		else if (take)
		begin
			// old state with its recoverable bit goes to the save pair
			save_restore_addr_reg  <= save_addr;
			save_restore_state_reg <= machine_state_reg;
			machine_state_reg      <= msr_take;
			redirect_reg.valid     <= 1'b1;
			redirect_reg.addr      <= {EVS_VEC_BASE, evs_vec_off(exc_sel)};
			active_exc_reg         <= exc_sel;
		end
		else
		begin
			redirect_reg.valid <= 1'b0;
			// return restores, else software write
			if (handler_return)
				machine_state_reg <= save_restore_state_reg;
			else if (msr_wr)
				machine_state_reg <= msr_wdata;
		end
	end

	// redirect address always base plus offset of the kind
	property p_vec;
		@(posedge sys_clk) disable iff (reset)
		redirect_reg.valid |-> redirect_reg.addr == {EVS_VEC_BASE, evs_vec_off(active_exc_reg)};
	endproperty
	a_vec: assert property (p_vec) else $error("redirect address not base plus offset");

	// save pair holds the state before entry, supervisor after
	property p_save;
		@(posedge sys_clk) disable iff (reset)
		take |=> save_restore_state_reg == $past(machine_state_reg)
			&& !machine_state_reg[EVS_MSR_PR] && redirect_reg.valid;
	endproperty
	a_save: assert property (p_save) else $error("state not saved on entry");

	// async kinds only with an empty queue and enable set
	property p_async;
		@(posedge sys_clk) disable iff (reset)
		take && (exc_sel == EVS_X_EXT || exc_sel == EVS_X_DEC || exc_sel == EVS_X_SMI
			|| exc_sel == EVS_X_PERF || exc_sel == EVS_X_THERM) |-> cq_empty && ee;
	endproperty
	a_async: assert property (p_async) else $error("async taken with busy queue or masked");

	// reserved offset never produced
	property p_unused;
		@(posedge sys_clk) disable iff (reset)
		redirect_reg.valid |-> redirect_reg.addr[19:0] != EVS_OFF_UNUSED;
	endproperty
	a_unused: assert property (p_unused) else $error("reserved vector produced");

	// machine check only with checks enabled
	property p_mck;
		@(posedge sys_clk) disable iff (reset)
		redirect_reg.valid && active_exc_reg == EVS_X_MCHECK |-> $past(me);
	endproperty
	a_mck: assert property (p_mck) else $error("check taken while disabled");

	// faulting instruction held back and its address saved
	property p_hold;
		@(posedge sys_clk) disable iff (reset)
		take && sync_any && exc_sel == sync_sel && exc_sel != EVS_X_SYSCALL
			|-> cmpl_hold ##1 save_restore_addr_reg == $past(cmpl.addr);
	endproperty
	a_hold: assert property (p_hold) else $error("faulting instruction not held");

	// system call resumes one instruction later
	property p_sc;
		@(posedge sys_clk) disable iff (reset)
		redirect_reg.valid && active_exc_reg == EVS_X_SYSCALL
			|-> save_restore_addr_reg == $past(cmpl.addr) + EVS_INSTR_BYTES;
	endproperty
	a_sc: assert property (p_sc) else $error("system call resume address wrong");

	// no back to back entries except nonmaskable preemption
	property p_one;
		@(posedge sys_clk) disable iff (reset)
		redirect_reg.valid |-> !take || nmi_req;
	endproperty
	a_one: assert property (p_one) else $error("second exception without gap");

	// held hard reset pin reaches the reset vector
	property p_rst;
		@(posedge sys_clk) disable iff (reset)
		$rose(hard_reset_pin) ##1 hard_reset_pin[*3]
			|-> ##[0:2] (redirect_reg.valid && active_exc_reg == EVS_X_RESET);
	endproperty
	a_rst: assert property (p_rst) else $error("hard reset pin not vectored");

	// branch completing under branch trace leaves trace owed
	property p_trace;
		@(posedge sys_clk) disable iff (reset)
		retire && be && cmpl.is_branch && !cmpl.is_isync |=> trace_pend_reg;
	endproperty
	a_trace: assert property (p_trace) else $error("branch trace lost");
endmodule

// ### verilog/evs_pkg.sv
// Purpose: shared constants and types of the exception vector sequencer
// Assumes: 32-bit effective addresses, vector offsets in the low 20 bits
// Notes: machine state bit positions are fixed here for the whole block
package evs_pkg;
	// vector offsets, low 20 address bits
	localparam logic [19:0] EVS_OFF_NONE    = 20'h00000;
	localparam logic [19:0] EVS_OFF_RESET   = 20'h00100;
	localparam logic [19:0] EVS_OFF_MCHECK  = 20'h00200;
	localparam logic [19:0] EVS_OFF_DSI     = 20'h00300;
	localparam logic [19:0] EVS_OFF_ISI     = 20'h00400;
	localparam logic [19:0] EVS_OFF_EXT     = 20'h00500;
	localparam logic [19:0] EVS_OFF_ALIGN   = 20'h00600;
	localparam logic [19:0] EVS_OFF_PROGRAM = 20'h00700;
	localparam logic [19:0] EVS_OFF_FPU     = 20'h00800;
	localparam logic [19:0] EVS_OFF_DEC     = 20'h00900;
	localparam logic [19:0] EVS_OFF_SYSCALL = 20'h00c00;
	localparam logic [19:0] EVS_OFF_TRACE   = 20'h00d00;
	localparam logic [19:0] EVS_OFF_UNUSED  = 20'h00e00;
	localparam logic [19:0] EVS_OFF_PERF    = 20'h00f00;
	localparam logic [19:0] EVS_OFF_INSTR_BREAKPOINT_REG    = 20'h01300;
	localparam logic [19:0] EVS_OFF_SMI     = 20'h01400;
	localparam logic [19:0] EVS_OFF_THERM   = 20'h01700;
	// high-order fetch prefix above the offset
	localparam logic [11:0] EVS_VEC_BASE    = 12'h000;
	// machine state bit positions
	localparam int EVS_EXT_IRQ_ENABLE_BIT = 15;
	localparam int EVS_MSR_PR = 14;
	localparam int EVS_CHECK_ENABLE_BIT = 12;
	localparam int EVS_SINGLE_STEP_ENABLE = 10;
	localparam int EVS_BRANCH_TRACE_ENABLE = 9;
	localparam int EVS_INSTR_TRANSLATE_ENABLE = 5;
	localparam int EVS_RECOVERABLE_BIT = 1;
	// machine state after reset
	localparam logic [31:0] EVS_MSR_RST      = 32'h0000_0000;
	// bits cleared on entry: ee, pr, se, be, ir, ri
	localparam logic [31:0] EVS_MSR_TAKE_CLR = 32'h0000_c622;
	// size of one instruction in bytes
	localparam logic [31:0] EVS_INSTR_BYTES  = 32'h0000_0004;
	// exception kinds
	typedef enum logic [3:0] {
		EVS_X_NONE    = 4'h0,
		EVS_X_RESET   = 4'h1,
		EVS_X_MCHECK  = 4'h2,
		EVS_X_DSI     = 4'h3,
		EVS_X_ISI     = 4'h4,
		EVS_X_EXT     = 4'h5,
		EVS_X_ALIGN   = 4'h6,
		EVS_X_PROGRAM = 4'h7,
		EVS_X_FPU     = 4'h8,
		EVS_X_DEC     = 4'h9,
		EVS_X_SYSCALL = 4'ha,
		EVS_X_TRACE   = 4'hb,
		EVS_X_PERF    = 4'hc,
		EVS_X_INSTR_BREAKPOINT_REG    = 4'hd,
		EVS_X_SMI     = 4'he,
		EVS_X_THERM   = 4'hf
	} evs_exc_t;
	// sequencer states
	typedef enum logic [0:0] {
		EVS_ST_RUN  = 1'b0,
		EVS_ST_STOP = 1'b1
	} evs_state_t;
	// next-completing instruction and its causes
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [31:0] next_addr;
		logic        is_branch;
		logic        is_isync;
		logic        system_call_op;
		logic        instr_storage_fault;
		logic        data_fault;
		logic        align_fault;
		logic        program_fault;
		logic        fpu_unavail;
	} evs_cmpl_t;
	// fetch redirect
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
	} evs_redirect_t;
	// offset for each exception kind
	function automatic logic [19:0] evs_vec_off(input evs_exc_t e);
		case (e)
			EVS_X_RESET:   return EVS_OFF_RESET;
			EVS_X_MCHECK:  return EVS_OFF_MCHECK;
			EVS_X_DSI:     return EVS_OFF_DSI;
			EVS_X_ISI:     return EVS_OFF_ISI;
			EVS_X_EXT:     return EVS_OFF_EXT;
			EVS_X_ALIGN:   return EVS_OFF_ALIGN;
			EVS_X_PROGRAM: return EVS_OFF_PROGRAM;
			EVS_X_FPU:     return EVS_OFF_FPU;
			EVS_X_DEC:     return EVS_OFF_DEC;
			EVS_X_SYSCALL: return EVS_OFF_SYSCALL;
			EVS_X_TRACE:   return EVS_OFF_TRACE;
			EVS_X_PERF:    return EVS_OFF_PERF;
			EVS_X_INSTR_BREAKPOINT_REG:    return EVS_OFF_INSTR_BREAKPOINT_REG;
			EVS_X_SMI:     return EVS_OFF_SMI;
			EVS_X_THERM:   return EVS_OFF_THERM;
			default:       return EVS_OFF_NONE;
		endcase
	endfunction
endpackage

// ### verilog/evs_sync.sv
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module evs_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// levels
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_reg; // first stage

	// two stages, cleared on reset
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			meta_reg <= '0;
			dout     <= '0;
		end
		else
		begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end
endmodule

// ### test/evs_pin_model.sv
// Purpose: system logic model that drives the core's reset, check and request pins
// Assumes: every pin is an active-high level
// Notes: pins change just after a falling edge, so the core never samples a moving level
`timescale 1ns/1ps
module evs_pin_model (
	// clock
	input  wire logic sys_clk,
	// pins toward the core
	output logic      hard_reset_pin,
	output logic      soft_reset_pin,
	output logic      check_request_pin,
	output logic      transfer_error_ack,
	output logic      ext_irq_pin,
	output logic      sys_mgmt_irq_pin
);
	// pin levels, bit 0 hard reset up to bit 5 system management
	logic [5:0] pins = 6'h00;
	// fan the levels out to the pins
	assign {sys_mgmt_irq_pin, ext_irq_pin, transfer_error_ack} = pins[5:3];
	assign {check_request_pin, soft_reset_pin, hard_reset_pin} = pins[2:0];
	// set all levels at the next falling edge, requests held until lowered
	task automatic set(input logic [5:0] v);
		@(negedge sys_clk);
		pins = v;
	endtask
endmodule

// ### test/test_evs_sequencer.sv
// Purpose: self-checking bench of the exception vector sequencer
// Assumes: inputs move at the falling edge, outputs read 1 ns after the rising edge or at the falling edge, cmpl_hold 1 ns after it
// Notes: pins come from the pin model, everything else from here
`timescale 1ns/1ps
module test_evs_sequencer;
	import evs_pkg::*;
	// clock, reset and counters
	logic          sys_clk = 1'b0;
	logic          reset = 1'b1;
	int            err_total = 0;
	int            n_checks = 0;
	// on-chip sources
	logic [2:0]    double_bit_err = 3'h0;
	logic          down_counter_msb = 1'b0;
	logic          perf_limit_hit = 1'b0;
	logic          perf_irq_enable = 1'b0;
	logic          thermal_enable = 1'b0;
	logic [1:0]    thermal_over = 2'h0;
	// completion side and setup
	evs_cmpl_t     cmpl = '0;
	logic          cq_empty = 1'b0;
	logic [31:0]   restart_addr = 32'h0000_4000;
	logic [31:0]   instr_breakpoint_reg = 32'h0;
	logic          breakpoint_translate_bit = 1'b0;
	logic          breakpoint_enable_bit = 1'b0;
	logic          msr_wr = 1'b0;
	logic [31:0]   msr_wdata = 32'h0;
	logic          handler_return = 1'b0;
	// pins and outputs
	logic          hard_reset_pin, soft_reset_pin, check_request_pin;
	logic          transfer_error_ack, ext_irq_pin, sys_mgmt_irq_pin;
	logic          cmpl_hold, dispatch_hold, check_stop_reg;
	evs_redirect_t redirect_reg;
	evs_exc_t      active_exc_reg;
	logic [31:0]   save_restore_addr_reg, save_restore_state_reg, machine_state_reg;
	// 50 MHz clock
	always #10 sys_clk = ~sys_clk;
	// far side pins
	evs_pin_model u_evs_pin_model (.sys_clk, .hard_reset_pin, .soft_reset_pin, .check_request_pin,
		.transfer_error_ack, .ext_irq_pin, .sys_mgmt_irq_pin);
	// block under test
	evs_sequencer u_evs_sequencer (.sys_clk, .reset, .hard_reset_pin, .soft_reset_pin,
		.check_request_pin, .transfer_error_ack, .ext_irq_pin, .sys_mgmt_irq_pin, .double_bit_err,
		.down_counter_msb, .perf_limit_hit, .perf_irq_enable, .thermal_enable, .thermal_over, .cmpl,
		.cq_empty, .restart_addr, .cmpl_hold, .dispatch_hold, .instr_breakpoint_reg,
		.breakpoint_translate_bit, .breakpoint_enable_bit, .msr_wr, .msr_wdata, .handler_return,
		.redirect_reg, .active_exc_reg, .save_restore_addr_reg, .save_restore_state_reg,
		.machine_state_reg, .check_stop_reg);
	// closing report
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// software write of machine state, one-cycle strobe
	task automatic set_msr(input logic [31:0] v);
		@(negedge sys_clk);
		msr_wr = 1'b1;
		msr_wdata = v;
		@(negedge sys_clk);
		msr_wr = 1'b0;
	endtask
	// bounded wait for a redirect, then judge target and saved address
	task automatic wait_vec(input logic [19:0] off, input logic [31:0] save);
		int i;
		i = 0;
		while (redirect_reg.valid !== 1'b1 && i < 40)
		begin
			@(posedge sys_clk);
			#1;
			i++;
		end
		chk({31'h0, redirect_reg.valid}, 32'h1);
		chk(redirect_reg.addr, {EVS_VEC_BASE, off});
		chk(save_restore_addr_reg, save);
		if (redirect_reg.valid !== 1'b1)
			tally_and_finish();
	endtask
	// no redirect may appear for n cycles
	task automatic no_vec(input int n);
		int hits;
		hits = 0;
		repeat (n)
		begin
			@(posedge sys_clk);
			#1;
			if (redirect_reg.valid !== 1'b0)
				hits++;
		end
		chk(32'(hits), 32'h0);
	endtask
	// instruction-caused faults, system call and breakpoint, each followed by a return
	task automatic t_sync;
		logic [19:0] offs [7] = '{EVS_OFF_DSI, EVS_OFF_ISI, EVS_OFF_ALIGN, EVS_OFF_PROGRAM,
			EVS_OFF_FPU, EVS_OFF_SYSCALL, EVS_OFF_INSTR_BREAKPOINT_REG};
		logic [31:0] old;
		for (int k = 0; k < 7; k++)
		begin
			// breakpoint case runs with translation on, so the translate bit must follow it
			old = 32'h0000_d002 | ((k == 6) ? 32'h0000_0020 : 32'h0000_0000);
			set_msr(old);
			@(negedge sys_clk);
			cmpl = '0;
			cmpl.valid = 1'b1;
			cmpl.addr = 32'h0000_2000 + 32'(k * 16);
			cmpl.next_addr = cmpl.addr + EVS_INSTR_BYTES;
			cmpl.data_fault = (k == 0);
			cmpl.instr_storage_fault = (k == 1);
			cmpl.align_fault = (k == 2);
			cmpl.program_fault = (k == 3);
			cmpl.fpu_unavail = (k == 4);
			cmpl.system_call_op = (k == 5);
			instr_breakpoint_reg = cmpl.addr;
			breakpoint_enable_bit = (k == 6);
			breakpoint_translate_bit = (k == 6);
			#1;
			chk({31'h0, cmpl_hold}, 32'h1);
			wait_vec(offs[k], (k == 5) ? cmpl.next_addr : cmpl.addr);
			chk(save_restore_state_reg, old);
			chk(machine_state_reg, old & ~EVS_MSR_TAKE_CLR);
			@(negedge sys_clk);
			cmpl = '0;
			breakpoint_enable_bit = 1'b0;
			handler_return = 1'b1;
			@(negedge sys_clk);
			handler_return = 1'b0;
			chk(machine_state_reg, old);
		end
		$display("test sync done");
	endtask
	// single step, branch trace, and a synchronising instruction that must not trace
	task automatic t_trace;
		for (int j = 0; j < 3; j++)
		begin
			set_msr((j == 0) ? 32'h0000_0400 : (j == 1) ? 32'h0000_0200 : 32'h0000_0600);
			@(negedge sys_clk);
			cmpl = '0;
			cmpl.valid = 1'b1;
			cmpl.addr = 32'h0000_3000;
			cmpl.next_addr = 32'h0000_3010;
			cmpl.is_branch = (j != 0);
			cmpl.is_isync = (j == 2);
			@(negedge sys_clk);
			cmpl = '0;
			if (j < 2)
				wait_vec(EVS_OFF_TRACE, 32'h0000_3010);
			else
				no_vec(6);
		end
		$display("test trace done");
	endtask
	// machine check taken, check-stop with checks off, then both reset pins
	task automatic t_nmi;
		// first an on-chip double-bit error, then the transfer error pin
		for (int k = 0; k < 2; k++)
		begin
			set_msr(32'h0000_1002);
			restart_addr = 32'h0000_5000 + 32'(k * 16);
			if (k == 0)
			begin
				@(negedge sys_clk);
				double_bit_err = 3'h4;
			end
			else
				u_evs_pin_model.set(6'h08);
			wait_vec(EVS_OFF_MCHECK, restart_addr);
			chk(save_restore_state_reg, 32'h0000_1002);
			@(negedge sys_clk);
			double_bit_err = 3'h0;
			u_evs_pin_model.set(6'h00);
			repeat (4) @(negedge sys_clk);
		end
		set_msr(32'h0);
		u_evs_pin_model.set(6'h04);
		repeat (8) @(negedge sys_clk);
		chk({31'h0, check_stop_reg}, 32'h1);
		u_evs_pin_model.set(6'h01);
		wait_vec(EVS_OFF_RESET, restart_addr);
		// hold the pin long enough for the reset-vector assertion to engage
		repeat (3) @(negedge sys_clk);
		u_evs_pin_model.set(6'h00);
		repeat (6) @(negedge sys_clk);
		chk({31'h0, check_stop_reg}, 32'h0);
		u_evs_pin_model.set(6'h02);
		wait_vec(EVS_OFF_RESET, restart_addr);
		u_evs_pin_model.set(6'h00);
		repeat (6) @(negedge sys_clk);
		$display("test nmi done");
	endtask
	// maskable sources: external request held back while the queue is busy, then each taken in turn
	task automatic t_async;
		logic [19:0] offs [5] = '{EVS_OFF_EXT, EVS_OFF_SMI, EVS_OFF_THERM, EVS_OFF_DEC, EVS_OFF_PERF};
		set_msr(32'h0000_8000);
		u_evs_pin_model.set(6'h10);
		no_vec(8);
		chk({31'h0, dispatch_hold}, 32'h1);
		for (int k = 0; k < 5; k++)
		begin
			// each entry clears the enable, so re-enable after the previous source is gone
			if (k > 0)
				set_msr(32'h0000_8000);
			@(negedge sys_clk);
			cq_empty = 1'b1;
			restart_addr = 32'h0000_6000 + 32'(k * 16);
			thermal_enable = (k == 2);
			thermal_over = (k == 2) ? 2'h2 : 2'h0;
			down_counter_msb = (k == 3);
			perf_irq_enable = (k == 4);
			perf_limit_hit = (k == 4);
			if (k == 1)
				u_evs_pin_model.set(6'h20);
			wait_vec(offs[k], restart_addr);
			u_evs_pin_model.set(6'h00);
			{thermal_enable, down_counter_msb, perf_limit_hit} = 3'h0;
			repeat (3) @(negedge sys_clk);
		end
		$display("test async done");
	endtask
	// main sequence
	initial
	begin
		repeat (10) @(negedge sys_clk);
		reset = 1'b0;
		repeat (3) @(negedge sys_clk);
		t_sync();
		t_trace();
		t_nmi();
		t_async();
		tally_and_finish();
	end
endmodule
